// ===== inc/timer2_pkg.sv
// Constants and carrier types for the 16-bit capture/reload timer.
// Assumes a classic Wishbone master with a 32-bit data bus and byte addresses.
// Operation
// R1: The overflow flag (bit 7) is set by every counter overflow unless a baud select is 1, and only software clears it.
// R2: With the trigger enable set, the external flag (bit 6) is set by each trigger-pin fall that captures or reloads.
// R3: The receive baud select (bit 5) picks this timer's overflow (1) or the other timer's overflow (0) for receive.
// R4: The transmit baud select (bit 4) picks this timer's overflow (1) or the other timer's overflow (0) for transmit.
// R5: With the trigger enable (bit 3) set and both baud selects clear, a trigger-pin fall captures or reloads.
// R6: The run control holds the counter when 0 and lets it advance when 1.
// R7: With the counter/timer select (bit 1) clear, the counter advances once every 2 system clocks while running.
// R8: With the counter/timer select set, the counter advances on each falling edge of the count pin.
// R9: With the capture/reload select (bit 0) clear, the counter reloads on overflow and on enabled trigger falls.
// R10: With the capture/reload select set, each enabled trigger fall copies the counter into the reload value.
// R11: A baud select of 1 overrides the capture/reload select and forces reload on overflow.
// R12: The reload/capture value is two software bytes, low and high, both reset to zero.
// R13: The counter is readable and writable as a low and a high byte, both reset to zero.
// R14: Reload copies the reload value into the counter, capture copies the counter out, overflow is a wrap past all ones.
// R15: The overflow and external flags together drive one timer interrupt, high while either is set.
package timer2_pkg;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL     = 8'hC8;
   localparam logic [7:0] IDX_RCAP_LOW    = 8'hCA;
   localparam logic [7:0] IDX_RCAP_HIGH   = 8'hCB;
   localparam logic [7:0] IDX_COUNT_LOW   = 8'hCC;
   localparam logic [7:0] IDX_COUNT_HIGH  = 8'hCD;
   localparam logic [7:0] IDX_EVENT_STAT  = 8'hD0;
   localparam logic [7:0] IDX_EVENT_MASK  = 8'hD1;

   localparam int ADDR_WIDTH = 12;

   // Control fields
   localparam int BIT_OVERFLOW_FLAG = 7;
   localparam int BIT_EXT_FLAG      = 6;
   localparam int BIT_RX_SELECT     = 5;
   localparam int BIT_TX_SELECT     = 4;
   localparam int BIT_TRIGGER_EN    = 3;
   localparam int BIT_RUN           = 2;
   localparam int BIT_COUNTER_SEL   = 1;
   localparam int BIT_CAPTURE_SEL   = 0;

   // Event status and mask fields
   localparam int EVT_OVERFLOW = 0;
   localparam int EVT_TRIGGER  = 1;

   // Reset values
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [15:0] RCAP_RESET    = 16'h0000;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [1:0]  EVENT_RESET   = 2'h0;
   localparam logic [1:0]  MASK_RESET    = 2'h0;

   // Timing: timer mode advances once per this many system clocks
   localparam int TIMER_DIVIDE = 2;

   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

   typedef struct packed {
      logic overflow_flag;
      logic external_trigger_flag;
      logic receive_baud_select;
      logic transmit_baud_select;
      logic trigger_pin_enable;
      logic run_control;
      logic counter_timer_select;
      logic capture_reload_select;
   } second_timer_control_t;

   typedef struct packed {
      logic                  cyc;
      logic                  stb;
      logic                  we;
      logic [ADDR_WIDTH-1:0] adr;
      logic [3:0]            sel;
      logic [31:0]           dat;
   } wb_req_t;

   typedef struct packed {
      logic                  cnt_meta;
      logic                  cnt_sync;
      logic                  cnt_prev;
      logic                  trig_meta;
      logic                  trig_sync;
      logic                  trig_prev;
      logic                  prescale;
      second_timer_control_t ctrl;
      logic [15:0]           rcap;
      logic [15:0]           count;
      logic [1:0]            events;
      logic [1:0]            mask;
      logic                  ack;
      logic [31:0]           rdata;
      logic                  rx_baud_tick;
      logic                  tx_baud_tick;
      logic                  timer_irq;
      logic                  irq;
   } state_t;

endpackage

// ===== logic/timer2_capture_reload_control.sv
// 16-bit timer/counter with capture, auto-reload and baud clock output.
// Assumes a classic Wishbone master on clk; the count and trigger pins are asynchronous.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns

module timer2_capture_reload_control (
   // Clock, reset, enable
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   // Wishbone slave
   input  wire timer2_pkg::wb_req_t wb_req,
   output logic                   wb_ack,
   output logic [31:0]            wb_dat_o,
   // External pins
   input  wire logic              count_input_pin,
   input  wire logic              trigger_pin,
   // Serial port baud sources
   input  wire logic              timer1_overflow,
   output logic                   rx_baud_tick,
   output logic                   tx_baud_tick,
   // Interrupts
   output logic                   timer_irq,
   output logic                   irq
);

   timer2_pkg::state_t st;
   timer2_pkg::state_t next_st;
   timer2_pkg::state_t reset_st;

   logic        baud_mode;
   logic        cnt_fall;
   logic        trig_fall;
   logic        inc;
   logic        ovf;
   logic        trig_act;
   logic        reload;
   logic        capture;
   logic        req;
   logic        bus_write;
   logic        bus_read_done;
   logic        addr_hit;
   logic [7:0]  idx;
   logic [7:0]  wbyte;
   logic        write_count;
   logic        write_rcap;

   always_comb begin
      reset_st          = '0;
      reset_st.ctrl     = timer2_pkg::second_timer_control_t'(timer2_pkg::CONTROL_RESET);
      reset_st.rcap     = timer2_pkg::RCAP_RESET;
      reset_st.count    = timer2_pkg::COUNT_RESET;
      reset_st.events   = timer2_pkg::EVENT_RESET;
      reset_st.mask     = timer2_pkg::MASK_RESET;
   end

   // Derived controls
   assign baud_mode = st.ctrl.receive_baud_select | st.ctrl.transmit_baud_select;
   // Edges only seen on synchronised copies
   assign cnt_fall  = st.cnt_prev & ~st.cnt_sync;
   assign trig_fall = st.trig_prev & ~st.trig_sync;

   // Timer mode uses the prescaler phase; counter mode uses the pin edge
   assign inc = st.ctrl.run_control & (st.ctrl.counter_timer_select ? cnt_fall : st.prescale); // R6 R7 R8
   assign ovf = inc & (st.count == timer2_pkg::COUNT_ALL_ONES); // R14

   // Trigger pin is dead while either baud select is set
   assign trig_act = st.ctrl.trigger_pin_enable & trig_fall & ~baud_mode; // R5
   assign reload   = (ovf & (baud_mode | ~st.ctrl.capture_reload_select)) // R9 R11
                   | (trig_act & ~st.ctrl.capture_reload_select); // R9
   assign capture  = trig_act & st.ctrl.capture_reload_select; // R10

   // Bus decode; a write lands on the edge that shows ack to the master
   assign req           = wb_req.cyc & wb_req.stb;
   assign idx           = wb_req.adr[9:2];
   assign addr_hit      = (wb_req.adr[timer2_pkg::ADDR_WIDTH-1:10] == 2'h0);
   assign bus_write     = req & wb_req.we & st.ack & wb_req.sel[0] & addr_hit;
   assign bus_read_done = req & ~wb_req.we & st.ack & addr_hit;
   assign wbyte         = wb_req.dat[7:0];
   assign write_count   = bus_write & ((idx == timer2_pkg::IDX_COUNT_LOW) | (idx == timer2_pkg::IDX_COUNT_HIGH));
   assign write_rcap    = bus_write & ((idx == timer2_pkg::IDX_RCAP_LOW) | (idx == timer2_pkg::IDX_RCAP_HIGH));

   always_comb begin
      next_st = st;

      // Two-stage synchronisers, then an edge history stage
      next_st.cnt_meta  = count_input_pin;
      next_st.cnt_sync  = st.cnt_meta;
      next_st.cnt_prev  = st.cnt_sync;
      next_st.trig_meta = trigger_pin;
      next_st.trig_sync = st.trig_meta;
      next_st.trig_prev = st.trig_sync;

      // Prescaler restarts whenever timer mode is not running
      if (st.ctrl.run_control && !st.ctrl.counter_timer_select) begin
         next_st.prescale = ~st.prescale; // R7
      end else begin
         next_st.prescale = 1'b0;
      end

      // Counter datapath
      if (reload) begin
         next_st.count = st.rcap; // R14
      end else if (inc) begin
         next_st.count = st.count + 16'h0001; // R7 R8
      end
      if (capture) begin
         next_st.rcap = st.count; // R10 R14
      end

      // Software writes override the hardware update of the same counter or reload byte
      if (bus_write) begin
         case (idx)
            timer2_pkg::IDX_CONTROL: begin
               next_st.ctrl = timer2_pkg::second_timer_control_t'(wbyte);
            end
            timer2_pkg::IDX_RCAP_LOW: begin
               next_st.rcap[7:0] = wbyte; // R12
            end
            timer2_pkg::IDX_RCAP_HIGH: begin
               next_st.rcap[15:8] = wbyte; // R12
            end
            timer2_pkg::IDX_COUNT_LOW: begin
               next_st.count[7:0] = wbyte; // R13
            end
            timer2_pkg::IDX_COUNT_HIGH: begin
               next_st.count[15:8] = wbyte; // R13
            end
            timer2_pkg::IDX_EVENT_MASK: begin
               next_st.mask = wbyte[1:0];
            end
            default: begin
               next_st.mask = st.mask;
            end
         endcase
      end

      // Hardware set wins over a software clear in the same cycle
      if (ovf && !baud_mode) begin
         next_st.ctrl.overflow_flag = 1'b1; // R1
      end
      if (trig_act) begin
         next_st.ctrl.external_trigger_flag = 1'b1; // R2
      end

      // Clear only what the read returned, so an event landing on the request edge is not lost; sets win
      if (bus_read_done && (idx == timer2_pkg::IDX_EVENT_STAT)) begin
         next_st.events = st.events & ~st.rdata[1:0];
      end
      if (ovf) begin
         next_st.events[timer2_pkg::EVT_OVERFLOW] = 1'b1;
      end
      if (trig_act) begin
         next_st.events[timer2_pkg::EVT_TRIGGER] = 1'b1;
      end

      // Ack one cycle after the request, drop the cycle after
      next_st.ack = req & ~st.ack;
      if (req && !st.ack) begin
         next_st.rdata = 32'h0000_0000;
         if (addr_hit) begin
            case (idx)
               timer2_pkg::IDX_CONTROL: begin
                  next_st.rdata[7:0] = st.ctrl;
               end
               timer2_pkg::IDX_RCAP_LOW: begin
                  next_st.rdata[7:0] = st.rcap[7:0];
               end
               timer2_pkg::IDX_RCAP_HIGH: begin
                  next_st.rdata[7:0] = st.rcap[15:8];
               end
               timer2_pkg::IDX_COUNT_LOW: begin
                  next_st.rdata[7:0] = st.count[7:0];
               end
               timer2_pkg::IDX_COUNT_HIGH: begin
                  next_st.rdata[7:0] = st.count[15:8];
               end
               timer2_pkg::IDX_EVENT_STAT: begin
                  next_st.rdata[1:0] = st.events;
               end
               timer2_pkg::IDX_EVENT_MASK: begin
                  next_st.rdata[1:0] = st.mask;
               end
               default: begin
                  next_st.rdata = 32'h0000_0000;
               end
            endcase
         end
      end

      // Serial mode gating belongs to the serial port; this only picks the source
      next_st.rx_baud_tick = st.ctrl.receive_baud_select ? ovf : timer1_overflow; // R3
      next_st.tx_baud_tick = st.ctrl.transmit_baud_select ? ovf : timer1_overflow; // R4

      next_st.timer_irq = next_st.ctrl.overflow_flag | next_st.ctrl.external_trigger_flag; // R15
      next_st.irq       = |(next_st.events & next_st.mask);
   end

   // Clock enable low freezes everything, the bus handshake included
   always_ff @(posedge clk) begin
      if (reset) begin
         st <= reset_st; // R12 R13
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign wb_ack       = st.ack;
   assign wb_dat_o     = st.rdata;
   assign rx_baud_tick = st.rx_baud_tick;
   assign tx_baud_tick = st.tx_baud_tick;
   assign timer_irq    = st.timer_irq;
   assign irq          = st.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_ovf_flag_set: assert property (ce && ovf && !baud_mode |=> st.ctrl.overflow_flag) // R1
      else $error("overflow flag not set on overflow");

   a_ovf_baud_quiet: assert property (ce && ovf && baud_mode && !st.ctrl.overflow_flag && !bus_write // R1
      |=> !st.ctrl.overflow_flag)
      else $error("overflow flag set in baud mode");

   a_ext_flag_set: assert property (ce && trig_fall && st.ctrl.trigger_pin_enable && !baud_mode // R2
      |=> st.ctrl.external_trigger_flag)
      else $error("external flag not set on trigger");

   a_rx_baud_source: assert property (ce |=> rx_baud_tick == // R3
      ($past(st.ctrl.receive_baud_select) ? $past(ovf) : $past(timer1_overflow)))
      else $error("receive baud source wrong");

   a_tx_baud_source: assert property (ce |=> tx_baud_tick == // R4
      ($past(st.ctrl.transmit_baud_select) ? $past(ovf) : $past(timer1_overflow)))
      else $error("transmit baud source wrong");

   a_trigger_ignored: assert property (ce && trig_fall && !st.ctrl.trigger_pin_enable // R5
      && !inc && !bus_write |=> $stable(st.count) && $stable(st.rcap))
      else $error("disabled trigger pin changed the timer");

   // An enabled trigger fall may still reload a stopped counter
   a_run_hold: assert property (ce && !st.ctrl.run_control && !trig_act && !bus_write |=> $stable(st.count)) // R6
      else $error("counter moved while stopped");

   a_timer_gap: assert property (ce && inc && !st.ctrl.counter_timer_select && !bus_write |=> !inc) // R7
      else $error("timer mode advanced on two clocks in a row");

   a_timer_rate: assert property (ce && inc && !st.ctrl.counter_timer_select && !bus_write // R7
      ##1 ce && !bus_write |=> inc)
      else $error("timer mode rate not one per two clocks");

   a_counter_edge: assert property (ce && st.ctrl.run_control && st.ctrl.counter_timer_select // R8
      && cnt_fall && !reload && !write_count |=> st.count == $past(st.count) + 16'h0001)
      else $error("counter mode missed a count pin edge");

   a_auto_reload: assert property (ce && ovf && !write_count |=> st.count == $past(st.rcap) // R9 R11
      || $past(st.ctrl.capture_reload_select) && !$past(baud_mode))
      else $error("overflow did not reload");

   a_capture_value: assert property (ce && trig_act && st.ctrl.capture_reload_select && !write_rcap // R10
      |=> st.rcap == $past(st.count))
      else $error("capture did not copy the counter");

   // Reset is the antecedent here, so the default disable must not apply
   a_reset_values: assert property (@(posedge clk) disable iff (1'b0) reset |=> st.count == timer2_pkg::COUNT_RESET // R12 R13
      && st.rcap == timer2_pkg::RCAP_RESET)
      else $error("counter or reload value not zero after reset");

   a_timer_irq: assert property (timer_irq == (st.ctrl.overflow_flag | st.ctrl.external_trigger_flag)) // R15
      else $error("timer interrupt does not follow the flags");

endmodule

// ===== sim/pin_model.sv
// Far-side model: count pin, trigger pin and the other timer's overflow.
// Assumes clk is the system clock; both pins idle high as if pulled up.
`timescale 1ns/1ns
module pin_model (
   // Clock
   input  wire logic clk,
   // Toward the timer
   output logic      count_input_pin,
   output logic      trigger_pin,
   output logic      timer1_overflow
);
   initial begin
      count_input_pin = 1'b1;
      trigger_pin     = 1'b1;
      timer1_overflow = 1'b0;
   end
   // Phases of 4 clocks outlast the two-stage synchroniser
   task automatic fall(input logic trig, input int n);
      repeat (n) begin
         @(posedge clk);
         if (trig) trigger_pin <= 1'b0; else count_input_pin <= 1'b0;
         repeat (4) @(posedge clk);
         if (trig) trigger_pin <= 1'b1; else count_input_pin <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic t1_pulse();
      @(posedge clk);
      timer1_overflow <= 1'b1;
      @(posedge clk);
      timer1_overflow <= 1'b0;
   endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the capture/reload timer.
// Assumes pin_model drives the pins and registers are reached over classic Wishbone.
`timescale 1ns/1ns
module tb_top;
   logic                clk;
   logic                reset;
   timer2_pkg::wb_req_t req;
   logic                ack;
   logic [31:0]         rdat;
   logic                cnt_pin;
   logic                trig_pin;
   logic                t1_ovf;
   logic                rx_tick;
   logic                tx_tick;
   logic                timer_irq;
   logic                irq;
   logic [7:0]          rd;
   int                  n_errors;
   int                  n_tests;
   int                  cycles;
   int                  t_ack;
   int                  t_run;
   typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} row_t;
   row_t rows [7] = '{'{timer2_pkg::IDX_RCAP_LOW, 8'h34, 8'h34}, '{timer2_pkg::IDX_RCAP_HIGH, 8'h12, 8'h12},
      '{timer2_pkg::IDX_COUNT_LOW, 8'hFE, 8'hFE}, '{timer2_pkg::IDX_COUNT_HIGH, 8'hFF, 8'hFF},
      '{timer2_pkg::IDX_EVENT_MASK, 8'h01, 8'h01}, '{8'hFF, 8'h55, 8'h00}, '{timer2_pkg::IDX_CONTROL, 8'h08, 8'h08}};
   logic [7:0] zero_idx [7] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0, 8'hD1};

   timer2_capture_reload_control dut_u (
      .clk(clk), .reset(reset), .ce(1'b1), .wb_req(req), .wb_ack(ack), .wb_dat_o(rdat),
      .count_input_pin(cnt_pin), .trigger_pin(trig_pin), .timer1_overflow(t1_ovf),
      .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .timer_irq(timer_irq), .irq(irq));
   pin_model p_u (.clk(clk), .count_input_pin(cnt_pin), .trigger_pin(trig_pin), .timer1_overflow(t1_ovf));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("mismatches=%0d comparisons=%0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // A limit long past the longest scenario
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Timer phase at start and stop is unknown, so allow one count either way
   task automatic chk_near(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if ($isunknown(got) || got > exp + 8'h01 || got + 8'h01 < exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Ack is sampled at the rising edge; the edge that sees it high takes the data and releases
   task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      req <= '{1'b1, 1'b1, we, {2'b00, idx, 2'b00}, 4'hF, {24'h0, wd}};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = rdat[7:0];
      t_ack = cycles;
      req <= '0;
   endtask

   task automatic wait_hi(ref logic s, input int lim);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (s !== 1'b1 && k < lim);
   endtask

   initial begin
      reset = 1'b1;
      req = '0;
      n_errors = 0;
      n_tests = 0;
      cycles = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         wb(1'b1, rows[i].idx, rows[i].wd);
         wb(1'b0, rows[i].idx, 8'h00);
         chk(rd, rows[i].exp);
      end
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h04);
      wait_hi(timer_irq, 30);
      chk({7'h0, irq}, 8'h01);
      wb(1'b0, timer2_pkg::IDX_CONTROL, 8'h00);
      chk(rd, 8'h84);
      wb(1'b0, timer2_pkg::IDX_COUNT_HIGH, 8'h00);
      chk(rd, 8'h12);
      wb(1'b0, timer2_pkg::IDX_EVENT_STAT, 8'h00);
      chk(rd, 8'h01);
      wb(1'b0, timer2_pkg::IDX_EVENT_STAT, 8'h00);
      chk(rd, 8'h00);
      chk({7'h0, irq}, 8'h00);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h00);
      wb(1'b1, timer2_pkg::IDX_COUNT_LOW, 8'h00);
      chk({7'h0, timer_irq}, 8'h00);
      wb(1'b1, timer2_pkg::IDX_COUNT_HIGH, 8'h00);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h04);
      t_run = t_ack;
      repeat (100) @(posedge clk);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h00);
      t_run = (t_ack - t_run) / 2;
      wb(1'b0, timer2_pkg::IDX_COUNT_LOW, 8'h00);
      chk_near(rd, t_run[7:0]);
      repeat (20) @(posedge clk);
      wb(1'b0, timer2_pkg::IDX_COUNT_LOW, 8'h00);
      chk_near(rd, t_run[7:0]);
      wb(1'b1, timer2_pkg::IDX_COUNT_LOW, 8'h00);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h06);
      p_u.fall(1'b0, 5);
      wb(1'b0, timer2_pkg::IDX_COUNT_LOW, 8'h00);
      chk(rd, 8'h05);
      wb(1'b1, timer2_pkg::IDX_COUNT_LOW, 8'h77);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h07);
      p_u.fall(1'b1, 1);
      wb(1'b0, timer2_pkg::IDX_CONTROL, 8'h00);
      chk(rd, 8'h07);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h0F);
      p_u.fall(1'b1, 1);
      wb(1'b0, timer2_pkg::IDX_RCAP_LOW, 8'h00);
      chk(rd, 8'h77);
      wb(1'b0, timer2_pkg::IDX_CONTROL, 8'h00);
      chk(rd, 8'h4F);
      chk({6'h0, timer_irq, irq}, 8'h02);
      wb(1'b0, timer2_pkg::IDX_EVENT_STAT, 8'h00);
      chk(rd, 8'h02);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h0E);
      wb(1'b1, timer2_pkg::IDX_RCAP_LOW, 8'h21);
      p_u.fall(1'b1, 1);
      wb(1'b0, timer2_pkg::IDX_COUNT_LOW, 8'h00);
      chk(rd, 8'h21);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h3E);
      p_u.fall(1'b1, 1);
      wb(1'b0, timer2_pkg::IDX_CONTROL, 8'h00);
      chk(rd, 8'h3E);
      wb(1'b1, timer2_pkg::IDX_COUNT_LOW, 8'hFE);
      wb(1'b1, timer2_pkg::IDX_COUNT_HIGH, 8'hFF);
      // A high reload byte apart from zero tells a forced reload from a plain wrap
      wb(1'b1, timer2_pkg::IDX_RCAP_HIGH, 8'h12);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h35);
      wait_hi(rx_tick, 30);
      chk({6'h0, rx_tick, tx_tick}, 8'h03);
      wb(1'b0, timer2_pkg::IDX_CONTROL, 8'h00);
      chk(rd, 8'h35);
      wb(1'b1, timer2_pkg::IDX_CONTROL, 8'h00);
      wb(1'b0, timer2_pkg::IDX_COUNT_HIGH, 8'h00);
      chk(rd, 8'h12);
      fork
         p_u.t1_pulse();
         wait_hi(rx_tick, 6);
      join
      chk({6'h0, rx_tick, tx_tick}, 8'h03);
      @(posedge clk);
      reset <= 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      foreach (zero_idx[i]) begin
         wb(1'b0, zero_idx[i], 8'h00);
         chk(rd, 8'h00);
      end
      report_and_stop();
   end
endmodule
